// >>> logic/tep_timer_pins.sv
// Purpose: timer reactions to external count, clock and trigger pins
// Assumes: pins are sampled by clk_in; pin pulses last over two clocks
// Notes: timer 2 clock pin is two-way; enable is active low
`timescale 1ns/100ps

// Summary of operation
// - timer 0/1 counter counts count input falls
// - capture mode counts timer 2 clock pin falls
// - capture mode trigger fall copies count to capture
// - reload mode trigger fall reloads count
// - up-down mode trigger level sets direction
// - clock-out mode drives timer 2 clock pin
module tep_timer_pins #(
  parameter int CNT_W = tep_pkg::TEP_CNT_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] timer01_count_input_in,
  input wire tep_pkg::tep_t01_cfg_s [1:0] t01_cfg_in,
  input wire logic [1:0] t01_tick_in,
  input wire tep_pkg::tep_t2_cfg_s t2_cfg_in,
  input wire logic t2_tick_in,
  input wire logic timer2_clock_pin_in,
  output logic timer2_clock_pin_out,
  output logic timer2_clock_pin_oe_n_out,
  input wire logic timer2_trigger_input_in,
  output logic [1:0][CNT_W-1:0] t01_count_out,
  output logic [CNT_W-1:0] t2_count_out,
  output logic [CNT_W-1:0] t2_capture_out,
  output logic t2_event_out
);
  import tep_pkg::*;

  // the count pair and reload path are built for 16 bits only
  if (CNT_W != 16) begin : g_bad_cnt_w
    $error("tep_timer_pins: CNT_W must be 16");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // meta stage is read only by the second stage; edges use stages 2/3
  logic [3:0] sync1_r, sync2_r, sync3_r;
  logic [3:0] pins;
  logic [3:0] fall;
  assign pins = {timer2_trigger_input_in, timer2_clock_pin_in,
                 timer01_count_input_in};

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      sync3_r <= 4'hF;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign fall = sync3_r & ~sync2_r;

  // ----------------------------------------------------------------
  // timers 0 and 1
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] t01_r [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_t01
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          t01_r[gi] <= TEP_CNT_RST;
        end else if (t01_cfg_in[gi].run) begin
          if (t01_cfg_in[gi].counter_mode) begin
            if (fall[gi]) begin
              t01_r[gi] <= t01_r[gi] + 16'h0001;
            end
          end else if (t01_tick_in[gi]) begin
            t01_r[gi] <= t01_r[gi] + 16'h0001;
          end
        end
      end
      assign t01_count_out[gi] = t01_r[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // timer 2
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] t2_r, cap_r;
  logic evt_r, clk_out_r;
  logic t2_step;
  logic trig_fall, trig_lvl;
  assign trig_fall = fall[3];
  assign trig_lvl = sync2_r[3];
  // capture mode takes its clock from the pin, others from the core tick
  always_comb begin
    t2_step = t2_tick_in;
    if (t2_cfg_in.mode == TEP_T2_CAPTURE) begin
      t2_step = fall[2];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      t2_r <= TEP_CNT_RST;
    end else if (t2_cfg_in.mode == TEP_T2_RELOAD && trig_fall) begin
      t2_r <= t2_cfg_in.reload;
    end else if (t2_cfg_in.run && t2_step) begin
      case (t2_cfg_in.mode)
        TEP_T2_UPDOWN: begin
          if (trig_lvl) begin
            t2_r <= t2_r + 16'h0001;
          end else begin
            t2_r <= t2_r - 16'h0001;
          end
        end
        TEP_T2_CLKOUT: begin
          if (t2_r == 16'hFFFF) begin
            t2_r <= t2_cfg_in.reload;
          end else begin
            t2_r <= t2_r + 16'h0001;
          end
        end
        default: begin
          t2_r <= t2_r + 16'h0001;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap_r <= TEP_CAP_RST;
    end else if (t2_cfg_in.mode == TEP_T2_CAPTURE && trig_fall) begin
      cap_r <= t2_r;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      evt_r <= 1'b0;
    end else begin
      evt_r <= trig_fall && (t2_cfg_in.mode == TEP_T2_CAPTURE ||
                             t2_cfg_in.mode == TEP_T2_RELOAD);
    end
  end

  // toggle on each overflow so the pin carries half the overflow rate
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_out_r <= 1'b0;
    end else if (t2_cfg_in.mode != TEP_T2_CLKOUT) begin
      clk_out_r <= 1'b0;
    end else if (t2_cfg_in.run && t2_step && t2_r == 16'hFFFF) begin
      clk_out_r <= ~clk_out_r;
    end
  end

  assign timer2_clock_pin_out = clk_out_r;
  assign timer2_clock_pin_oe_n_out = (t2_cfg_in.mode != TEP_T2_CLKOUT);
  assign t2_count_out = t2_r;
  assign t2_capture_out = cap_r;
  assign t2_event_out = evt_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_fall0;
    sync3_r[0] && !sync2_r[0];
  endsequence

  property p_t0_count;
    @(posedge clk_in) disable iff (!nrst_in)
      (s_fall0 and (t01_cfg_in[0].run && t01_cfg_in[0].counter_mode))
      |=> t01_r[0] == $past(t01_r[0]) + 16'h0001;
  endproperty
  a_t0_count: assert property (p_t0_count)
    else $error("timer 0 missed a pin fall");

  property p_t0_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      (t01_cfg_in[0].counter_mode && !fall[0]) |=> $stable(t01_r[0]);
  endproperty
  a_t0_hold: assert property (p_t0_hold)
    else $error("timer 0 counted without a fall");

  property p_cap;
    @(posedge clk_in) disable iff (!nrst_in)
      (t2_cfg_in.mode == TEP_T2_CAPTURE && trig_fall)
      |=> cap_r == $past(t2_r) && evt_r;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture did not take the count");

  property p_cap_clk;
    @(posedge clk_in) disable iff (!nrst_in)
      (t2_cfg_in.mode == TEP_T2_CAPTURE && t2_cfg_in.run && fall[2])
      |=> t2_r == $past(t2_r) + 16'h0001;
  endproperty
  a_cap_clk: assert property (p_cap_clk)
    else $error("capture mode ignored the clock pin");

  property p_reload;
    @(posedge clk_in) disable iff (!nrst_in)
      (t2_cfg_in.mode == TEP_T2_RELOAD && trig_fall)
      |=> t2_r == $past(t2_cfg_in.reload);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not load the count");

  property p_down;
    @(posedge clk_in) disable iff (!nrst_in)
      (t2_cfg_in.mode == TEP_T2_UPDOWN && t2_cfg_in.run && t2_step
       && !trig_lvl) |=> t2_r == $past(t2_r) - 16'h0001;
  endproperty
  a_down: assert property (p_down)
    else $error("down count wrong");

  property p_up;
    @(posedge clk_in) disable iff (!nrst_in)
      (t2_cfg_in.mode == TEP_T2_UPDOWN && t2_cfg_in.run && t2_step
       && trig_lvl) |=> t2_r == $past(t2_r) + 16'h0001;
  endproperty
  a_up: assert property (p_up)
    else $error("up count wrong");

  property p_clkout;
    @(posedge clk_in) disable iff (!nrst_in)
      (t2_cfg_in.mode == TEP_T2_CLKOUT && t2_cfg_in.run && t2_step
       && t2_r == 16'hFFFF)
      |=> timer2_clock_pin_out != $past(timer2_clock_pin_out)
          && t2_r == $past(t2_cfg_in.reload);
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock pin not driven in clock-out mode");
endmodule

// >>> logic/tep_pkg.sv
// Purpose: shared constants and carriers for the timer pin event block
// Assumes: one system clock, pins synchronous after the two-stage sampler
// Notes: counter widths are 16 bits, as for the timer 2 count pair
package tep_pkg;
  localparam int TEP_CNT_W = 16;
  localparam logic [15:0] TEP_CNT_RST = 16'h0000;
  localparam logic [15:0] TEP_RELOAD_RST = 16'h0000;
  localparam logic [15:0] TEP_CAP_RST = 16'h0000;
  localparam logic [15:0] TEP_CLKOUT_DIV_RST = 16'h0001;

  typedef enum logic [1:0] {
    TEP_T2_CAPTURE,
    TEP_T2_RELOAD,
    TEP_T2_UPDOWN,
    TEP_T2_CLKOUT
  } tep_t2_mode_e;

  // timer 2 configuration carried from the core
  typedef struct packed {
    tep_t2_mode_e mode;
    logic run;
    logic [15:0] reload;
  } tep_t2_cfg_s;

  // timer 0/1 configuration
  typedef struct packed {
    logic run;
    logic counter_mode;
  } tep_t01_cfg_s;
endpackage

// >>> verif/tep_pin_model.sv
// Purpose: external circuitry that drives the timer pins
// Assumes: driven at the falling clock edge, idle level high
// Notes: pulses are two clocks low, two high, never shorter
`timescale 1ns/100ps
module tep_pin_model (
  input wire logic clk_in,
  output logic [1:0] cnt_pin_out,
  output logic clk_pin_out,
  output logic trig_out
);
  initial begin
    cnt_pin_out = 2'h3;
    clk_pin_out = 1'h1;
    trig_out = 1'h1;
  end
  // 0,1 count pins, 2 clock pin, 3 trigger; spacing kept wide
  task automatic fall(input int which);
    @(negedge clk_in);
    if (which < 2) cnt_pin_out[which] = 1'h0;
    else if (which == 2) clk_pin_out = 1'h0;
    else trig_out = 1'h0;
    repeat (2) @(negedge clk_in);
    cnt_pin_out = 2'h3;
    clk_pin_out = 1'h1;
    trig_out = 1'h1;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// >>> verif/timer_external_pin_events_tb.sv
// Purpose: self-checking bench of the timer pin reactions
// Assumes: responses settle within four clocks of a pin fall
// Notes: timer 0/1 internal ticks move counts only in test_t01_tick, elsewhere only pins do
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module timer_external_pin_events_tb;
  import tep_pkg::*;
  logic clk_in;
  logic nrst_in;
  logic [1:0] cnt_pin, t01_tick;
  logic clk_pin, trig, t2_tick, pin_out, oe_n, event_p;
  tep_t01_cfg_s [1:0] t01_cfg;
  tep_t2_cfg_s t2_cfg;
  logic [1:0][15:0] t01_cnt;
  logic [15:0] t2_cnt, t2_cap;
  int errors = 0, checks = 0, cycles = 0, ev_cnt = 0;
  // the pin model drives the pin while oe_n is high, the timer drives it while oe_n is low
  wire pin_lvl = oe_n ? clk_pin : pin_out;
  tep_pin_model u_pins (.clk_in(clk_in), .cnt_pin_out(cnt_pin),
    .clk_pin_out(clk_pin), .trig_out(trig));
  tep_timer_pins u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .timer01_count_input_in(cnt_pin), .t01_cfg_in(t01_cfg),
    .t01_tick_in(t01_tick), .t2_cfg_in(t2_cfg), .t2_tick_in(t2_tick),
    .timer2_clock_pin_in(pin_lvl), .timer2_clock_pin_out(pin_out),
    .timer2_clock_pin_oe_n_out(oe_n), .timer2_trigger_input_in(trig),
    .t01_count_out(t01_cnt), .t2_count_out(t2_cnt),
    .t2_capture_out(t2_cap), .t2_event_out(event_p));
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end
  // the event stands one cycle, so exactly one falling edge sees it
  always @(negedge clk_in) begin
    if (event_p === 1'h1) ev_cnt++;
  end
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end
  task automatic tick2();
    @(negedge clk_in) t2_tick = 1'h1;
    @(negedge clk_in) t2_tick = 1'h0;
  endtask
  task automatic tick01(input int i);
    @(negedge clk_in) t01_tick[i] = 1'h1;
    @(negedge clk_in) t01_tick[i] = 1'h0;
  endtask
  // timer 1 stopped, so its pin falls must not count
  task automatic test_t01();
    t01_cfg = '{'{run: 1'h0, counter_mode: 1'h1},
                '{run: 1'h1, counter_mode: 1'h1}};
    repeat (3) u_pins.fall(0);
    u_pins.fall(1);
    `CHK(t01_cnt[0], 16'h0003)
    `CHK(t01_cnt[1], 16'h0000)
    $display("test t01 done");
  endtask
  // timer mode steps on the core tick only; counter mode only on pins
  task automatic test_t01_tick();
    t01_cfg[1] = '{run: 1'h1, counter_mode: 1'h0};
    tick01(1);
    tick01(1);
    u_pins.fall(1);
    `CHK(t01_cnt[1], 16'h0002)
    t01_cfg[1].counter_mode = 1'h1;
    tick01(1);
    u_pins.fall(1);
    `CHK(t01_cnt[1], 16'h0003)
    tick01(0);
    `CHK(t01_cnt[0], 16'h0003)
    $display("test t01 tick done");
  endtask
  task automatic test_capture();
    t2_cfg = '{mode: TEP_T2_CAPTURE, run: 1'h1, reload: 16'h0000};
    tick2(); // ignored in capture mode
    repeat (5) u_pins.fall(2);
    `CHK(t2_cnt, 16'h0005)
    u_pins.fall(3);
    `CHK(t2_cap, 16'h0005)
    `CHK(ev_cnt, 1)
    `CHK(event_p, 1'h0)
    @(negedge clk_in);
    `CHK(ev_cnt, 1)
    $display("test capture done");
  endtask
  task automatic test_reload_updown();
    t2_cfg = '{mode: TEP_T2_RELOAD, run: 1'h1, reload: 16'h1234};
    u_pins.fall(3);
    `CHK(t2_cnt, 16'h1234)
    `CHK(ev_cnt, 2)
    t2_cfg.mode = TEP_T2_UPDOWN;
    tick2();
    tick2();
    `CHK(t2_cnt, 16'h1236)
    @(negedge clk_in) u_pins.trig_out = 1'h0;
    repeat (3) @(negedge clk_in);
    tick2();
    `CHK(t2_cnt, 16'h1235)
    `CHK(ev_cnt, 2)
    u_pins.trig_out = 1'h1;
    $display("test reload updown done");
  endtask
  task automatic test_clkout();
    int n;
    t2_cfg = '{mode: TEP_T2_RELOAD, run: 1'h1, reload: 16'hFFFE};
    u_pins.fall(3);
    t2_cfg.mode = TEP_T2_CLKOUT;
    @(negedge clk_in);
    `CHK(oe_n, 1'h0)
    `CHK(pin_out, 1'h0)
    n = 0;
    while (pin_out !== 1'h1 && n < 4) begin
      tick2();
      n++;
    end
    `CHK(pin_out, 1'h1)
    `CHK(n, 2)
    `CHK(t2_cnt, 16'hFFFE)
    t2_cfg.mode = TEP_T2_RELOAD;
    @(negedge clk_in);
    `CHK(oe_n, 1'h1)
    $display("test clkout done");
  endtask
  // mid-run reset clears counts and capture; no false fall on release
  task automatic test_reset();
    @(negedge clk_in) nrst_in = 1'h0;
    repeat (2) @(negedge clk_in);
    `CHK(t01_cnt, 32'h0000_0000)
    `CHK(t2_cnt, 16'h0000)
    `CHK(t2_cap, 16'h0000)
    nrst_in = 1'h1;
    u_pins.fall(0);
    `CHK(t01_cnt, 32'h0000_0001)
    $display("test reset done");
  endtask
  initial begin
    nrst_in = 1'h0;
    t01_tick = 2'h0;
    t2_tick = 1'h0;
    t01_cfg = '0;
    t2_cfg = '0;
    repeat (20) @(negedge clk_in);
    nrst_in = 1'h1;
    test_t01();
    test_t01_tick();
    test_capture();
    test_reload_updown();
    test_clkout();
    test_reset();
    final_report();
  end
endmodule
